// file: dma_tag_defs.vh
// register offsets, field positions, reset values and fixed sizes of the tag-chained slave channel
// assumes bit 0 of each documented word is the most significant bit, bit 31 the least
`ifndef DMA_TAG_DEFS_VH
`define DMA_TAG_DEFS_VH

// ----------------------------------------------------------------
// register offsets on the register port
// ----------------------------------------------------------------
`define REG_STATUS_WORD 4'h0
`define REG_MEM_ADDRESS 4'h4
`define REG_BUF_CONTROL 4'h8

// ----------------------------------------------------------------
// channel status word fields (verilog bit index)
// ----------------------------------------------------------------
`define CSW_CTL_HI 31
`define CSW_CTL_LO 28
`define CSW_SLAVE 27
`define CSW_SYSMEM 26
`define CSW_TC_EN 25
`define CSW_DIR 24
`define CSW_NEXT_HI 23
`define CSW_NEXT_LO 12
`define CSW_LEN_HI 11
`define CSW_LEN_LO 0
`define CSW_TAG_LOAD_HI 26
`define CSW_RESET 32'h0000_0000
`define CTL_ENABLED 2'b01
`define NEXT_LAST 12'hfff

// ----------------------------------------------------------------
// buffer control word fields (verilog bit index)
// ----------------------------------------------------------------
`define BUF_DIRTY 31
`define BUF_PREF 30
`define BUF_INVAL 29
`define BUF_NEXT 28
`define BUF_RESV_W 28

// ----------------------------------------------------------------
// reset values and sizes
// ----------------------------------------------------------------
`define ADDR_RESET 32'h0000_0000
`define BUF_LAST 6'h3f
`define FIFO_WORDS 8

`endif

// file: dma_fifo.v
// small synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset and a global clock enable
`timescale 1ns/1ps

module dma_fifo #(
  parameter WIDTH = 41,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire mclk,
  input wire sys_rst,
  input wire ce,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  reg [WIDTH-1:0] store [0:DEPTH-1]; // entries, flops read combinationally at rd_ptr, so read data is not registered
  reg [AW-1:0] wr_ptr; // next slot to fill
  reg [AW-1:0] rd_ptr; // oldest entry
  reg [AW:0] fill; // entries held, one bit wider to tell full from empty

  wire do_push = in_valid & in_ready;
  wire do_pop = out_valid & out_ready;

  assign in_ready = (fill != DEPTH[AW:0]);
  assign out_valid = (fill != {(AW+1){1'b0}});
  assign out_data = store[rd_ptr];

  // pointer and fill bookkeeping; depth must be a power of two for the wrap
  always @(posedge mclk) begin
    if (sys_rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      fill <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (do_push) begin
        store[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        fill <= fill + 1'b1;
      end else if (do_pop && !do_push) begin
        fill <= fill - 1'b1;
      end
    end
  end

endmodule // dma_fifo

// file: dma_tag_channel.v
// one slave dma channel driven by a tag chain: status word, memory address, buffer control
// assumes a single clock, inputs synchronous to it, and a host store/load port for the registers
`timescale 1ns/1ps
`include "dma_tag_defs.vh"

module dma_tag_channel #(
  parameter BUFFERED = 1,
  parameter DUAL_BUF = 0,
  parameter FIFO_DEPTH = `FIFO_WORDS,
  parameter FIFO_AW = 3
) (
  input wire mclk,
  input wire sys_rst,
  input wire ce,
  input wire reg_wr,
  input wire reg_rd,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  input wire cmd_enable,
  input wire cmd_disable,
  input wire cmd_buf_inval,
  input wire cmd_next_inval,
  input wire xfer_valid,
  output wire xfer_ready,
  input wire [7:0] xfer_wdata,
  output reg [7:0] xfer_rdata,
  output reg xfer_rvalid,
  output reg terminal_count_pulse,
  output wire channel_enabled,
  output wire [3:0] error_code,
  output wire tag_req,
  output wire [11:0] tag_index,
  input wire tag_ack,
  input wire [31:0] tag_word0,
  input wire [31:0] tag_word4,
  output wire mem_req,
  output reg mem_we,
  output reg mem_sys,
  output reg [31:0] mem_addr,
  output reg [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  input wire mem_ack
);

  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam S_IDLE = 3'd0; // pick the next piece of work
  localparam S_MEM = 3'd1; // one direct byte access
  localparam S_FLUSH = 3'd2; // write the whole buffer back
  localparam S_PREF = 3'd3; // fill the buffer from memory
  localparam S_TAG = 3'd4; // reload from the tag table

  // ----------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------
  reg [31:0] csw; // channel status word
  reg [31:0] maddr; // channel memory address
  reg dirty; // buffer differs from memory
  reg pref; // buffer holds prefetched data
  reg inval; // buffer contents invalid
  reg nxt; // next buffer prefetched, storage only
  reg [7:0] buffer [0:63]; // 64-byte channel buffer
  reg [25:0] buf_blk; // memory block the buffer mirrors
  reg [25:0] op_blk; // block being prefetched
  reg [5:0] cnt; // byte index inside flush/prefetch
  reg [2:0] state;
  reg tag_pending; // chain reload owed before more bytes

  // ----------------------------------------------------------------
  // decoded fields
  // ----------------------------------------------------------------
  wire err_mode = |csw[`CSW_CTL_HI:`CSW_CTL_HI-1];
  // control meaning only while the top pair is zero
  wire enabled = !err_mode && (csw[`CSW_CTL_LO+1:`CSW_CTL_LO] == `CTL_ENABLED);
  wire slave = csw[`CSW_SLAVE];
  wire sys = csw[`CSW_SYSMEM];
  wire tc_en = csw[`CSW_TC_EN];
  wire dir_in = csw[`CSW_DIR];
  wire [11:0] next_idx = csw[`CSW_NEXT_HI:`CSW_NEXT_LO];
  wire [11:0] len = csw[`CSW_LEN_HI:`CSW_LEN_LO];
  wire use_buf = (BUFFERED != 0);

  assign channel_enabled = enabled;
  assign error_code = err_mode ? csw[`CSW_CTL_HI:`CSW_CTL_LO] : 4'h0;
  assign tag_index = next_idx;
  assign tag_req = (state == S_TAG);
  assign mem_req = (state == S_MEM) || (state == S_FLUSH) || (state == S_PREF);

  // ----------------------------------------------------------------
  // write fifo between device and memory
  // ----------------------------------------------------------------
  wire f_in_ready;
  wire f_valid;
  wire [40:0] f_data;
  wire f_sys = f_data[40];
  wire [31:0] f_addr = f_data[39:8];
  wire [7:0] f_byte = f_data[7:0];

  // bytes leave the device as soon as taken; counters move at push time so
  // the channel never accepts past the end of the chain
  wire accept_ok = enabled && slave && !tag_pending && (state != S_TAG);
  wire push = dir_in && xfer_valid && accept_ok && f_in_ready;
  wire f_hit = use_buf && f_sys && !inval && (f_addr[31:6] == buf_blk);
  wire r_hit = use_buf && sys && !inval && (maddr[31:6] == buf_blk);
  wire idle_free = (state == S_IDLE) && !tag_pending;
  wire drain_hit = idle_free && f_valid && f_hit;
  wire rd_take = idle_free && !dir_in && xfer_valid && accept_ok && !f_valid && r_hit;
  wire rd_mem_done = (state == S_MEM) && !mem_we && mem_ack;
  wire f_pop = drain_hit || ((state == S_MEM) && mem_we && mem_ack);
  wire advance = push || rd_take || rd_mem_done;
  assign xfer_ready = advance;

  dma_fifo #(
    .WIDTH(41),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ce(ce),
    .in_valid(push),
    .in_ready(f_in_ready),
    .in_data({sys, maddr, xfer_wdata}),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // ----------------------------------------------------------------
  // register readback
  // ----------------------------------------------------------------
  wire nxt_rd = (DUAL_BUF != 0) ? nxt : 1'b0;
  wire [31:0] bufc_rd = use_buf ? {dirty, pref, inval, nxt_rd, {`BUF_RESV_W{1'b0}}} : 32'h0000_0000;

  // registered load data, unmapped offsets read zero
  always @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce && reg_rd) begin
      case (reg_addr)
        `REG_STATUS_WORD: reg_rdata <= csw;
        `REG_MEM_ADDRESS: reg_rdata <= maddr;
        `REG_BUF_CONTROL: reg_rdata <= bufc_rd;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // main channel process
  // ----------------------------------------------------------------
  // software stores come first in the block so any hardware set in the
  // same cycle lands last and wins over a software clear
  always @(posedge mclk) begin
    if (sys_rst) begin
      csw <= `CSW_RESET;
      maddr <= `ADDR_RESET;
      dirty <= 1'b0;
      pref <= 1'b0;
      inval <= 1'b1;
      nxt <= 1'b0;
      buf_blk <= 26'h0;
      op_blk <= 26'h0;
      cnt <= 6'h0;
      state <= S_IDLE;
      tag_pending <= 1'b0;
      terminal_count_pulse <= 1'b0;
      xfer_rdata <= 8'h00;
      xfer_rvalid <= 1'b0;
      mem_we <= 1'b0;
      mem_sys <= 1'b0;
      mem_addr <= 32'h0000_0000;
      mem_wdata <= 8'h00;
    end else if (ce) begin
      terminal_count_pulse <= 1'b0;
      xfer_rvalid <= 1'b0;

      // host stores; a store to the status word also loads the error field from the stored top bits
      if (reg_wr) begin
        case (reg_addr)
          `REG_STATUS_WORD: csw <= reg_wdata;
          `REG_MEM_ADDRESS: maddr <= reg_wdata;
          `REG_BUF_CONTROL: begin
            if (use_buf) begin
              dirty <= reg_wdata[`BUF_DIRTY];
              pref <= reg_wdata[`BUF_PREF];
              inval <= reg_wdata[`BUF_INVAL];
              nxt <= reg_wdata[`BUF_NEXT];
            end
          end
          default: begin
          end
        endcase
      end

      // enable and disable commands; enable ignored in error mode
      if (cmd_enable && !err_mode) begin
        csw[`CSW_CTL_LO] <= 1'b1;
      end
      if (cmd_disable) begin
        csw[`CSW_CTL_LO] <= 1'b0;
      end
      if (cmd_buf_inval && use_buf) begin
        inval <= 1'b1;
        nxt <= 1'b0;
      end
      if (cmd_next_inval && use_buf) begin
        nxt <= 1'b0;
      end

      // per-byte bookkeeping; length holds count minus one
      if (advance) begin
        maddr <= maddr + 32'h0000_0001;
        if (len == 12'h000) begin
          if (tc_en || next_idx == `NEXT_LAST) begin
            terminal_count_pulse <= 1'b1;
          end
          if (next_idx == `NEXT_LAST) begin
            csw[`CSW_CTL_LO] <= 1'b0;
          end else begin
            tag_pending <= 1'b1;
          end
        end else begin
          csw[`CSW_LEN_HI:`CSW_LEN_LO] <= len - 12'h001;
        end
      end

      case (state)
        S_IDLE: begin
          if (tag_pending) begin
            state <= S_TAG;
          end else if (f_valid) begin
            if (f_hit) begin
              buffer[f_addr[5:0]] <= f_byte;
              dirty <= 1'b1;
            end else if (use_buf && f_sys) begin
              // miss on a buffered block: write back first if needed
              op_blk <= f_addr[31:6];
              cnt <= 6'h0;
              state <= dirty ? S_FLUSH : S_PREF;
              mem_we <= dirty;
              mem_sys <= 1'b1;
              mem_addr <= dirty ? {buf_blk, 6'h00} : {f_addr[31:6], 6'h00};
              mem_wdata <= buffer[0];
            end else begin
              // bus memory or unbuffered: one direct byte write
              state <= S_MEM;
              mem_we <= 1'b1;
              mem_sys <= f_sys;
              mem_addr <= f_addr;
              mem_wdata <= f_byte;
            end
          end else if (rd_take) begin
            xfer_rdata <= buffer[maddr[5:0]];
            xfer_rvalid <= 1'b1;
          end else if (use_buf && enabled && slave && sys && (inval || (!dir_in && xfer_valid && !r_hit))) begin
            // invalid buffer, or a read miss, pulls the block in
            op_blk <= maddr[31:6];
            cnt <= 6'h0;
            state <= dirty ? S_FLUSH : S_PREF;
            mem_we <= dirty;
            mem_sys <= 1'b1;
            mem_addr <= dirty ? {buf_blk, 6'h00} : {maddr[31:6], 6'h00};
            mem_wdata <= buffer[0];
          end else if (!dir_in && xfer_valid && accept_ok) begin
            state <= S_MEM;
            mem_we <= 1'b0;
            mem_sys <= sys;
            mem_addr <= maddr;
          end
        end
        S_MEM: begin
          if (mem_ack) begin
            if (!mem_we) begin
              xfer_rdata <= mem_rdata;
              xfer_rvalid <= 1'b1;
            end
            state <= S_IDLE;
          end
        end
        S_FLUSH: begin
          if (mem_ack) begin
            if (cnt == `BUF_LAST) begin
              // buffer now clean and invalid, go fetch the wanted block
              dirty <= 1'b0;
              pref <= 1'b0;
              inval <= 1'b1;
              nxt <= 1'b0;
              cnt <= 6'h0;
              state <= S_PREF;
              mem_we <= 1'b0;
              mem_addr <= {op_blk, 6'h00};
            end else begin
              cnt <= cnt + 6'h01;
              mem_addr <= {buf_blk, cnt + 6'h01};
              mem_wdata <= buffer[cnt + 6'h01];
            end
          end
        end
        S_PREF: begin
          if (mem_ack) begin
            buffer[cnt] <= mem_rdata;
            if (cnt == `BUF_LAST) begin
              buf_blk <= op_blk;
              pref <= 1'b1;
              inval <= 1'b0;
              state <= S_IDLE;
            end else begin
              cnt <= cnt + 6'h01;
              mem_addr <= {op_blk, cnt + 6'h01};
            end
          end
        end
        S_TAG: begin
          if (tag_ack) begin
            // status bits 0-4 stay; the rest follow the tag word
            csw[`CSW_TAG_LOAD_HI:0] <= tag_word0[`CSW_TAG_LOAD_HI:0];
            maddr <= tag_word4;
            tag_pending <= 1'b0;
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule // dma_tag_channel

// file: dma_mem_model.sv
// memory and tag table responder standing behind the channel's memory and tag ports
// assumes one clock shared with the channel and a synchronous active-high reset
`timescale 1ns/1ps

module dma_mem_model #(
  parameter DELAY = 2
) (
  input wire mclk,
  input wire sys_rst,
  input wire mem_req,
  input wire mem_we,
  input wire mem_sys,
  input wire [31:0] mem_addr,
  input wire [7:0] mem_wdata,
  output reg [7:0] mem_rdata,
  output reg mem_ack,
  input wire tag_req,
  output reg tag_ack,
  output reg [31:0] tag_word0,
  output reg [31:0] tag_word4
);
  // --------------------------------------------------
  // storage, counters
  // --------------------------------------------------
  reg [7:0] mem [0:8191]; // byte store indexed by low address bits
  integer rd_count; // reads answered
  integer wr_count; // writes answered
  integer wait_cnt; // cycles the current request has waited
  integer i;
  reg last_sys; // memory select seen on the last access

  // answer each request after DELAY cycles; read data and tag_word0 toggle when not answering, tag_word4 holds its value
  // reset refills memory with contents derived from the low address byte so a wrong low address byte shows up as wrong data
  always @(posedge mclk) begin
    if (sys_rst) begin
      for (i = 0; i < 8192; i = i + 1) begin
        mem[i] <= i[7:0] ^ 8'h5a;
      end
      mem_rdata <= 8'h00;
      tag_word0 <= 32'h0000_0000;
      tag_word4 <= 32'h0000_0000;
      last_sys <= 1'b1;
      mem_ack <= 1'b0;
      tag_ack <= 1'b0;
      wait_cnt <= 0;
      rd_count <= 0;
      wr_count <= 0;
    end else begin
      mem_ack <= 1'b0;
      tag_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      tag_word0 <= ~tag_word0;
      if ((mem_req && !mem_ack) || (tag_req && !tag_ack)) begin
        if (wait_cnt < DELAY) begin
          wait_cnt <= wait_cnt + 1;
        end else if (mem_req) begin
          wait_cnt <= 0;
          mem_ack <= 1'b1;
          last_sys <= mem_sys;
          if (mem_we) begin
            mem[mem_addr[12:0]] <= mem_wdata;
            wr_count <= wr_count + 1;
          end else begin
            mem_rdata <= mem[mem_addr[12:0]];
            rd_count <= rd_count + 1;
          end
        end else begin
          // last-tag entry: next index all ones, one byte
          wait_cnt <= 0;
          tag_ack <= 1'b1;
          tag_word0 <= 32'h00ff_f000;
          tag_word4 <= 32'h0000_0300;
        end
      end
    end
  end
endmodule // dma_mem_model

// file: dma_tag_channel_properties.sv
// concurrent checks on the tag-chained slave channel's ports
// assumes ce is held high and the design is built buffered without dual buffering
`timescale 1ns/1ps
`include "dma_tag_defs.vh"

module dma_tag_channel_properties (
  input wire mclk,
  input wire sys_rst,
  input wire reg_wr,
  input wire reg_rd,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_rdata,
  input wire cmd_enable,
  input wire cmd_disable,
  input wire xfer_ready,
  input wire xfer_rvalid,
  input wire terminal_count_pulse,
  input wire channel_enabled,
  input wire [3:0] error_code,
  input wire tag_req,
  input wire tag_ack,
  input wire [11:0] tag_index,
  input wire mem_req,
  input wire mem_ack,
  input wire [31:0] mem_addr,
  input wire mem_we
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // --------------------------------------------------
  // properties
  // --------------------------------------------------
  property p_enabled_no_error;
    channel_enabled |-> error_code == 4'h0;
  endproperty
  a_enabled_no_error: assert property (p_enabled_no_error) else $error("enabled with error code");

  property p_enable_cmd;
    cmd_enable && !cmd_disable && !reg_wr && error_code == 4'h0 |=> channel_enabled;
  endproperty
  a_enable_cmd: assert property (p_enable_cmd) else $error("enable command ignored");

  property p_disable_cmd;
    cmd_disable && !cmd_enable |=> !channel_enabled;
  endproperty
  a_disable_cmd: assert property (p_disable_cmd) else $error("disable command ignored");

  property p_error_mode;
    error_code != 4'h0 |-> error_code[3:2] != 2'b00 && !channel_enabled;
  endproperty
  a_error_mode: assert property (p_error_mode) else $error("error code without top bits");

  property p_refuse_disabled;
    !channel_enabled |-> !xfer_ready;
  endproperty
  a_refuse_disabled: assert property (p_refuse_disabled) else $error("byte taken while disabled");

  property p_tc_single;
    terminal_count_pulse |=> !terminal_count_pulse;
  endproperty
  a_tc_single: assert property (p_tc_single) else $error("terminal count longer than one cycle");

  property p_last_tag_off;
    terminal_count_pulse && tag_index == 12'hfff |-> ##[0:1] !channel_enabled;
  endproperty
  a_last_tag_off: assert property (p_last_tag_off) else $error("channel left enabled after last tag");

  property p_tag_hold;
    tag_req && !tag_ack |=> tag_req;
  endproperty
  a_tag_hold: assert property (p_tag_hold) else $error("tag request dropped early");

  property p_read_answer;
    xfer_rvalid |-> $past(xfer_ready);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read data without accept");

  property p_mem_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory request changed before ack");

  property p_next_zero;
    reg_rd && reg_addr == `REG_BUF_CONTROL |=> reg_rdata[28:0] == 29'h0;
  endproperty
  a_next_zero: assert property (p_next_zero) else $error("buffer control low bits not zero");
endmodule // dma_tag_channel_properties

bind dma_tag_channel dma_tag_channel_properties u_dma_tag_channel_properties (.mclk, .sys_rst, .reg_wr, .reg_rd,
  .reg_addr, .reg_rdata, .cmd_enable, .cmd_disable, .xfer_ready, .xfer_rvalid, .terminal_count_pulse,
  .channel_enabled, .error_code, .tag_req, .tag_ack, .tag_index, .mem_req, .mem_ack, .mem_addr, .mem_we);

// file: test_dma_tag_channel.sv
// testbench for the tag-chained slave channel: stores, loads, commands and device bytes
// assumes the memory responder model and the bound checker are compiled with it
`timescale 1ns/1ps
`include "dma_tag_defs.vh"

module test_dma_tag_channel;
  reg mclk, sys_rst, reg_wr, reg_rd, xfer_valid;
  reg cmd_enable, cmd_disable, cmd_buf_inval, cmd_next_inval;
  reg [3:0] reg_addr;
  reg [31:0] reg_wdata;
  reg [7:0] xfer_wdata;
  wire [31:0] reg_rdata, mem_addr, tag_word0, tag_word4;
  wire [7:0] xfer_rdata, mem_wdata, mem_rdata;
  wire [3:0] error_code;
  wire [11:0] tag_index;
  wire xfer_ready, xfer_rvalid, terminal_count_pulse, channel_enabled, tag_req, tag_ack;
  wire mem_req, mem_we, mem_sys, mem_ack;
  integer fails, check_count, tc_seen;
  localparam [31:0] ALL = 32'hffff_ffff;

  dma_tag_channel u_dma_tag_channel (.mclk, .sys_rst, .ce(1'b1), .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .cmd_enable, .cmd_disable, .cmd_buf_inval, .cmd_next_inval, .xfer_valid, .xfer_ready,
    .xfer_wdata, .xfer_rdata, .xfer_rvalid, .terminal_count_pulse, .channel_enabled, .error_code, .tag_req,
    .tag_index, .tag_ack, .tag_word0, .tag_word4, .mem_req, .mem_we, .mem_sys, .mem_addr, .mem_wdata,
    .mem_rdata, .mem_ack);
  dma_mem_model #(.DELAY(2)) u_dma_mem_model (.mclk, .sys_rst, .mem_req, .mem_we, .mem_sys, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_ack, .tag_req, .tag_ack, .tag_word0, .tag_word4);

  // --------------------------------------------------
  // clock, pulse counter, helpers
  // --------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // terminal count pulses seen so far
  always @(posedge mclk) begin
    if (sys_rst) tc_seen <= 0;
    else if (terminal_count_pulse === 1'b1) tc_seen <= tc_seen + 1;
  end

  // status word: slave set, no tc enable, last tag
  function [31:0] csw(input sys, input dir, input [11:0] len);
    csw = {4'h0, 1'b1, sys, 1'b0, dir, 12'hfff, len};
  endfunction

  task check(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task complete_run;
    begin
      $display("checks=%0d fails=%0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask

  task reg_store(input [3:0] a, input [31:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
    end
  endtask

  task reg_load(input [3:0] a, input [31:0] mask, input [31:0] exp);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      check(reg_rdata & mask, exp);
    end
  endtask

  // one-cycle pulse on {enable, disable, buffer invalidate, next invalidate}
  task cmd(input [3:0] c);
    begin
      {cmd_enable, cmd_disable, cmd_buf_inval, cmd_next_inval} <= c;
      @(posedge mclk);
      {cmd_enable, cmd_disable, cmd_buf_inval, cmd_next_inval} <= 4'h0;
      @(posedge mclk);
    end
  endtask

  // one device byte; ready is sampled mid-cycle, where it is settled
  task xfer(input w, input [7:0] d, input [7:0] exp);
    integer n;
    begin
      xfer_wdata <= d;
      xfer_valid <= 1'b1;
      n = 0;
      @(negedge mclk);
      while (xfer_ready !== 1'b1 && n < 3000) begin
        @(negedge mclk);
        n = n + 1;
      end
      check({31'h0, xfer_ready}, 32'h1);
      @(posedge mclk);
      xfer_valid <= 1'b0;
      @(negedge mclk);
      if (!w) check({23'h0, xfer_rvalid, xfer_rdata}, {24'h1, exp});
      @(posedge mclk);
    end
  endtask

  // a held request that must never be accepted
  task refused;
    integer n;
    begin
      xfer_valid <= 1'b1;
      n = 0;
      repeat (10) begin
        @(negedge mclk);
        if (xfer_ready === 1'b1) n = n + 1;
      end
      check(n, 0);
      @(posedge mclk);
      xfer_valid <= 1'b0;
      @(posedge mclk);
    end
  endtask

  // bounded wait for the responder's access counts, then exact compare
  task wait_mem(input integer rd, input integer wr);
    integer n;
    begin
      n = 0;
      while ((u_dma_mem_model.rd_count < rd || u_dma_mem_model.wr_count < wr) && n < 5000) begin
        @(posedge mclk);
        n = n + 1;
      end
      repeat (4) @(posedge mclk);
      check(u_dma_mem_model.rd_count, rd);
      check(u_dma_mem_model.wr_count, wr);
    end
  endtask

  // --------------------------------------------------
  // test sequence
  // --------------------------------------------------
  initial begin
    fails = 0;
    check_count = 0;
    {sys_rst, reg_wr, reg_rd, xfer_valid, reg_addr, reg_wdata, xfer_wdata} = {4'h8, 4'h0, 32'h0, 8'h0};
    {cmd_enable, cmd_disable, cmd_buf_inval, cmd_next_inval} = 4'h0;
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    reg_load(`REG_STATUS_WORD, ALL, 32'h0);
    reg_load(`REG_MEM_ADDRESS, ALL, 32'h0);
    reg_load(`REG_BUF_CONTROL, ALL, 32'h2000_0000);
    reg_load(4'hc, ALL, 32'h0);
    // bus memory, device to memory, two bytes (length one)
    reg_store(`REG_MEM_ADDRESS, 32'h0000_0100);
    reg_load(`REG_MEM_ADDRESS, ALL, 32'h0000_0100);
    reg_store(`REG_STATUS_WORD, csw(1'b0, 1'b1, 12'h001));
    reg_load(`REG_STATUS_WORD, ALL, csw(1'b0, 1'b1, 12'h001));
    cmd(4'h8);
    reg_load(`REG_STATUS_WORD, ALL, csw(1'b0, 1'b1, 12'h001) | 32'h1000_0000);
    check({31'h0, channel_enabled}, 32'h1);
    cmd(4'h4);
    check({31'h0, channel_enabled}, 32'h0);
    cmd(4'h8);
    xfer(1'b1, 8'ha1, 8'h00);
    xfer(1'b1, 8'hb2, 8'h00);
    wait_mem(0, 2);
    check({24'h0, u_dma_mem_model.mem[13'h0100]}, 32'ha1);
    check({24'h0, u_dma_mem_model.mem[13'h0101]}, 32'hb2);
    check({31'h0, u_dma_mem_model.last_sys}, 32'h0);
    check(tc_seen, 1);
    check({31'h0, channel_enabled}, 32'h0);
    refused;
    // bus memory to device, one byte
    reg_store(`REG_MEM_ADDRESS, 32'h0000_0237);
    reg_store(`REG_STATUS_WORD, csw(1'b0, 1'b0, 12'h000));
    cmd(4'h8);
    xfer(1'b0, 8'h00, 8'h6d);
    @(posedge mclk);
    check(tc_seen, 2);
    // error mode: enable refused, requests refused
    reg_store(`REG_STATUS_WORD, 32'ha000_0000);
    check({28'h0, error_code}, 32'ha);
    cmd(4'h8);
    check({31'h0, channel_enabled}, 32'h0);
    refused;
    reg_store(`REG_STATUS_WORD, 32'h0);
    // system memory, buffered: invalid after reset forces a prefetch
    reg_store(`REG_MEM_ADDRESS, 32'h0000_1040);
    reg_store(`REG_STATUS_WORD, csw(1'b1, 1'b0, 12'h03f));
    cmd(4'h8);
    wait_mem(65, 2);
    reg_load(`REG_BUF_CONTROL, ALL, 32'h4000_0000);
    xfer(1'b0, 8'h00, 8'h1a);
    reg_store(`REG_BUF_CONTROL, 32'h3000_0000);
    wait_mem(129, 2);
    reg_load(`REG_BUF_CONTROL, ALL, 32'h4000_0000);
    // device write dirties the buffer; invalidate flushes then refetches
    cmd(4'h4);
    reg_store(`REG_STATUS_WORD, csw(1'b1, 1'b1, 12'h03f));
    cmd(4'h8);
    xfer(1'b1, 8'hc3, 8'h00);
    repeat (20) @(posedge mclk);
    reg_load(`REG_BUF_CONTROL, 32'h8000_0000, 32'h8000_0000);
    cmd(4'h2);
    wait_mem(193, 66);
    check({24'h0, u_dma_mem_model.mem[13'h1041]}, 32'hc3);
    cmd(4'h1);
    reg_load(`REG_BUF_CONTROL, ALL, 32'h4000_0000);
    // bus memory write, next index one: expiry reloads from the tag table, no pulse
    reg_store(`REG_MEM_ADDRESS, 32'h0000_0180);
    reg_store(`REG_STATUS_WORD, 32'h1900_1000);
    xfer(1'b1, 8'hd4, 8'h00);
    wait_mem(193, 67);
    check({24'h0, u_dma_mem_model.mem[13'h0180]}, 32'hd4);
    reg_load(`REG_STATUS_WORD, ALL, 32'h18ff_f000);
    reg_load(`REG_MEM_ADDRESS, ALL, 32'h0000_0300);
    check(tc_seen, 2);
    complete_run;
  end

  // watchdog well beyond the roughly 1200 cycles the sequence needs
  initial begin
    repeat (60000) @(posedge mclk);
    fails = fails + 1;
    complete_run;
  end
endmodule // test_dma_tag_channel
